// ==== hdl/adcsc_map.vh ====
// constants for the converter sequencing block: register offsets, field positions,
// reset values and timing figures. included by bare name from the design files.
`ifndef ADCSC_MAP_VH
`define ADCSC_MAP_VH

// ****************************************************************
// register offsets (byte addresses, one word each)
// ****************************************************************
`define ADCSC_OFS_MODE      8'h00
`define ADCSC_OFS_CHAN      8'h04
`define ADCSC_OFS_RESULT    8'h08
`define ADCSC_OFS_STATUS    8'h0C
`define ADCSC_OFS_IRQ_STAT  8'h10
`define ADCSC_OFS_IRQ_MASK  8'h14
`define ADCSC_OFS_PORT      8'h18

// ****************************************************************
// field positions
// ****************************************************************
`define ADCSC_MODE_RUN_BIT   7
`define ADCSC_MODE_CMPEN_BIT 0
`define ADCSC_ST_DONE_BIT    0
`define ADCSC_ST_SUSPECT_BIT 1
`define ADCSC_ST_SETTLED_BIT 2
`define ADCSC_ST_BUSY_BIT    3
`define ADCSC_IRQ_END_BIT    0
`define ADCSC_IRQ_SUSP_BIT   1
`define ADCSC_IRQ_PORT_BIT   2

// ****************************************************************
// reset values
// ****************************************************************
`define ADCSC_MODE_RST      8'h00
`define ADCSC_CHAN_RST      2'h0
`define ADCSC_MASK_RST      3'h0

// ****************************************************************
// timing
// ****************************************************************
`define ADCSC_CLK_PERIOD_NS 4
`define ADCSC_SETTLE_NS     1000
`define ADCSC_SAMPLE_CYC    16
`define ADCSC_BIT_CYC       4

`endif

// ==== hdl/adcsc_sar.v ====
// successive-approximation sequencer: sampling interval, then one bit per step.
// assumes the comparator result arrives already synchronised to clk.
`timescale 1ns/10ps
`include "adcsc_map.vh"

module adcsc_sar #(
  parameter            RES_BITS   = 10,
  parameter [7:0]      SAMPLE_CYC = `ADCSC_SAMPLE_CYC,
  parameter [7:0]      BIT_CYC    = `ADCSC_BIT_CYC
) (
  input  wire                clk,
  input  wire                sys_rst,
  input  wire                run,
  input  wire [1:0]          chan,
  input  wire                cmp_hi,
  output reg                 sample_en,
  output reg  [1:0]          mux_sel,
  output reg  [RES_BITS-1:0] dac_code,
  output reg                 done,
  output reg  [RES_BITS-1:0] result,
  output reg  [1:0]          res_chan,
  output reg                 busy
);

  // ****************************************************************
  // states
  // ****************************************************************
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_SAMP = 2'h1;
  localparam [1:0] ST_CONV = 2'h2;

  reg [1:0]          state_q;
  reg [7:0]          cnt_q;
  reg [RES_BITS-1:0] bit_q;   // one-hot trial bit
  wire [RES_BITS-1:0] kept;

  // drop the trial bit when the input is below the trial level
  assign kept = cmp_hi ? dac_code : (dac_code & ~bit_q);

  // channel is latched at sampling start, so a later channel write
  // cannot disturb the conversion already under way
  always @(posedge clk) begin
    if (sys_rst) begin
      state_q   <= ST_IDLE;
      cnt_q     <= 8'h00;
      bit_q     <= {RES_BITS{1'b0}};
      sample_en <= 1'b0;
      mux_sel   <= 2'h0;
      dac_code  <= {RES_BITS{1'b0}};
      done      <= 1'b0;
      result    <= {RES_BITS{1'b0}};
      res_chan  <= 2'h0;
      busy      <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (run) begin
            state_q   <= ST_SAMP;
            mux_sel   <= chan;
            cnt_q     <= 8'h00;
            sample_en <= 1'b1;
            busy      <= 1'b1;
          end
        end
        ST_SAMP: begin
          if (!run) begin
            state_q   <= ST_IDLE;
            sample_en <= 1'b0;
            busy      <= 1'b0;
          end else if (cnt_q == SAMPLE_CYC - 8'h01) begin
            state_q   <= ST_CONV;
            sample_en <= 1'b0;
            cnt_q     <= 8'h00;
            bit_q     <= {1'b1, {(RES_BITS-1){1'b0}}};
            dac_code  <= {1'b1, {(RES_BITS-1){1'b0}}};
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        ST_CONV: begin
          if (!run) begin
            state_q <= ST_IDLE;
            busy    <= 1'b0;
          end else if (cnt_q == BIT_CYC - 8'h01) begin
            cnt_q <= 8'h00;
            if (bit_q[0]) begin
              state_q  <= ST_IDLE;
              done     <= 1'b1;
              result   <= kept;
              res_chan <= mux_sel;
              dac_code <= kept;
              busy     <= 1'b0;
            end else begin
              bit_q    <= bit_q >> 1;
              dac_code <= kept | (bit_q >> 1);
            end
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// ==== hdl/adcsc_ctrl.v ====
// control side of a four-channel successive-approximation converter: mode and
// channel registers, done flag, result, start-up check, shared port pins, interrupt.
// assumes a single-cycle register port and asynchronous pin and comparator inputs.
//
// Overview of operation
// - four analog pins double as a four-bit digital input port
// - a channel register write never touches the done flag
// - a conversion under way finishes on the old channel after a change
// - first result is suspect if start came under 1 us after enable
// - sampling capacitor charges only in the sampling interval
// - mode register: run is bit 7, comparator enable bit 0
// - mode or channel writes may spoil the result; read it first
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/10ps
`include "adcsc_map.vh"

module adcsc_ctrl #(
  parameter       RES_BITS   = 10,
  parameter [7:0] SAMPLE_CYC = `ADCSC_SAMPLE_CYC,
  parameter [7:0] BIT_CYC    = `ADCSC_BIT_CYC
) (
  input  wire                clk,
  input  wire                sys_rst,
  input  wire [7:0]          reg_addr,
  input  wire [31:0]         reg_wdata,
  input  wire                reg_wr,
  input  wire                reg_rd,
  output reg  [31:0]         reg_rdata,
  input  wire [3:0]          pin_level,
  input  wire                cmp_in,
  output reg                 comparator_en,
  output wire                sample_en,
  output wire [1:0]          mux_sel,
  output wire [RES_BITS-1:0] dac_code,
  output reg                 conv_end_irq,
  output reg                 irq
);

  // ****************************************************************
  // timing constants
  // ****************************************************************
  // least time, so round up to whole cycles
  localparam integer SETTLE_CYC_I =
    (`ADCSC_SETTLE_NS + `ADCSC_CLK_PERIOD_NS - 1) / `ADCSC_CLK_PERIOD_NS;
  localparam [8:0]   SETTLE_CYC   = SETTLE_CYC_I[8:0];

  // ****************************************************************
  // state
  // ****************************************************************
  reg [7:0]          converter_mode_reg_q;
  reg [1:0]          channel_select_reg_q;
  reg                conv_done_flag_q;
  reg [RES_BITS-1:0] result_q;
  reg [1:0]          res_chan_q;
  reg                res_suspect_q;
  reg [8:0]          settle_cnt_q;
  reg                settled_q;
  reg                first_pend_q;
  reg                first_bad_q;
  reg [2:0]          irq_stat_q;
  reg [2:0]          irq_mask_q;
  reg [3:0]          pin_s1_q;
  reg [3:0]          pin_s2_q;
  reg                cmp_s1_q;
  reg                cmp_s2_q;

  wire                conv_run_bit;
  wire                comparator_enable_bit;
  wire                eng_done;
  wire                eng_busy;
  wire [RES_BITS-1:0] eng_result;
  wire [1:0]          eng_chan;
  wire                wr_mode;
  wire                wr_chan;
  wire                wr_stat;
  wire                wr_mask;
  wire                rd_port;
  wire                rd_irq;
  wire                start_evt;
  wire                port_clash;
  wire [2:0]          irq_set;

  assign conv_run_bit          = converter_mode_reg_q[`ADCSC_MODE_RUN_BIT];
  assign comparator_enable_bit = converter_mode_reg_q[`ADCSC_MODE_CMPEN_BIT];

  // ****************************************************************
  // address decode
  // ****************************************************************
  assign wr_mode = reg_wr && (reg_addr == `ADCSC_OFS_MODE);
  assign wr_chan = reg_wr && (reg_addr == `ADCSC_OFS_CHAN);
  assign wr_stat = reg_wr && (reg_addr == `ADCSC_OFS_STATUS);
  assign wr_mask = reg_wr && (reg_addr == `ADCSC_OFS_IRQ_MASK);
  assign rd_port = reg_rd && (reg_addr == `ADCSC_OFS_PORT);
  assign rd_irq  = reg_rd && (reg_addr == `ADCSC_OFS_IRQ_STAT);

  // run bit going from clear to set is a conversion start
  assign start_evt  = wr_mode && reg_wdata[`ADCSC_MODE_RUN_BIT] && !conv_run_bit;
  // a port read during conversion costs resolution; flagged, not blocked
  assign port_clash = rd_port && eng_busy;
  assign irq_set    = {port_clash, eng_done && first_pend_q && first_bad_q, eng_done};

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  // pins are shared with the port, so their digital level is always sampled
  always @(posedge clk) begin
    if (sys_rst) begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= pin_level;
      pin_s2_q <= pin_s1_q;
      cmp_s1_q <= cmp_in;
      cmp_s2_q <= cmp_s1_q;
    end
  end

  // ****************************************************************
  // conversion engine
  // ****************************************************************
  adcsc_sar #(
    .RES_BITS   (RES_BITS),
    .SAMPLE_CYC (SAMPLE_CYC),
    .BIT_CYC    (BIT_CYC)
  ) u_sar (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .run       (conv_run_bit),
    .chan      (channel_select_reg_q),
    .cmp_hi    (cmp_s2_q),
    .sample_en (sample_en),
    .mux_sel   (mux_sel),
    .dac_code  (dac_code),
    .done      (eng_done),
    .result    (eng_result),
    .res_chan  (eng_chan),
    .busy      (eng_busy)
  );

  // ****************************************************************
  // control registers
  // ****************************************************************
  // a channel write does not abort the engine; the old channel may still finish
  always @(posedge clk) begin
    if (sys_rst) begin
      converter_mode_reg_q <= `ADCSC_MODE_RST;
      channel_select_reg_q <= `ADCSC_CHAN_RST;
      irq_mask_q           <= `ADCSC_MASK_RST;
      comparator_en        <= 1'b0;
    end else begin
      if (wr_mode) begin
        converter_mode_reg_q <= reg_wdata[7:0];
        comparator_en        <= reg_wdata[`ADCSC_MODE_CMPEN_BIT];
      end
      if (wr_chan) begin
        channel_select_reg_q <= reg_wdata[1:0];
      end
      if (wr_mask) begin
        irq_mask_q <= reg_wdata[2:0];
      end
    end
  end

  // ****************************************************************
  // comparator settling and first-result check
  // ****************************************************************
  // settle timer restarts whenever the comparator is switched off
  always @(posedge clk) begin
    if (sys_rst) begin
      settle_cnt_q <= 9'h000;
      settled_q    <= 1'b0;
      first_pend_q <= 1'b0;
      first_bad_q  <= 1'b0;
    end else begin
      if (!comparator_enable_bit) begin
        settle_cnt_q <= 9'h000;
        settled_q    <= 1'b0;
      end else if (settle_cnt_q == SETTLE_CYC - 9'h001) begin
        settled_q <= 1'b1;
      end else begin
        settle_cnt_q <= settle_cnt_q + 9'h001;
      end
      if (start_evt) begin
        first_pend_q <= 1'b1;
        first_bad_q  <= !(comparator_enable_bit && settled_q);
      end else if (eng_done) begin
        first_pend_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // result, done flag and end request
  // ****************************************************************
  // set wins over a software clear in the same cycle; only a status
  // write clears the flag, never a mode or channel write
  always @(posedge clk) begin
    if (sys_rst) begin
      conv_done_flag_q <= 1'b0;
      result_q         <= {RES_BITS{1'b0}};
      res_chan_q       <= 2'h0;
      res_suspect_q    <= 1'b0;
      conv_end_irq     <= 1'b0;
    end else begin
      conv_end_irq <= eng_done;
      if (eng_done) begin
        conv_done_flag_q <= 1'b1;
        result_q         <= eng_result;
        res_chan_q       <= eng_chan;
        res_suspect_q    <= first_pend_q && first_bad_q;
      end else if (wr_stat && reg_wdata[`ADCSC_ST_DONE_BIT]) begin
        conv_done_flag_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // interrupt status and output
  // ****************************************************************
  // read clears, but an event landing in the read cycle survives
  always @(posedge clk) begin
    if (sys_rst) begin
      irq_stat_q <= 3'h0;
      irq        <= 1'b0;
    end else begin
      if (rd_irq) begin
        irq_stat_q <= irq_set;
      end else begin
        irq_stat_q <= irq_stat_q | irq_set;
      end
      irq <= |((rd_irq ? irq_set : (irq_stat_q | irq_set)) & irq_mask_q);
    end
  end

  // ****************************************************************
  // read data, one cycle after the strobe
  // ****************************************************************
  // result register holds the last finished value; read it before mode
  // or channel writes since a late completion can replace it
  always @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      if (reg_addr == `ADCSC_OFS_MODE) begin
        reg_rdata <= {24'h000000, converter_mode_reg_q};
      end else if (reg_addr == `ADCSC_OFS_CHAN) begin
        reg_rdata <= {30'h00000000, channel_select_reg_q};
      end else if (reg_addr == `ADCSC_OFS_RESULT) begin
        reg_rdata <= {14'h0000, res_chan_q, {(16-RES_BITS){1'b0}}, result_q};
      end else if (reg_addr == `ADCSC_OFS_STATUS) begin
        reg_rdata <= {28'h0000000, eng_busy, settled_q, res_suspect_q, conv_done_flag_q};
      end else if (reg_addr == `ADCSC_OFS_IRQ_STAT) begin
        reg_rdata <= {29'h00000000, irq_stat_q};
      end else if (reg_addr == `ADCSC_OFS_IRQ_MASK) begin
        reg_rdata <= {29'h00000000, irq_mask_q};
      end else if (reg_addr == `ADCSC_OFS_PORT) begin
        reg_rdata <= {28'h0000000, pin_s2_q};
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule

// ==== testbench/adcsc_ctrl_chk.sv ====
// checker for the converter control block; sees only the top-level ports.
// assumes the bind below hands on the design's timing parameters.
`timescale 1ns/10ps
`include "adcsc_map.vh"

module adcsc_ctrl_chk #(
  parameter       RES_BITS   = 10,
  parameter [7:0] SAMPLE_CYC = `ADCSC_SAMPLE_CYC,
  parameter [7:0] BIT_CYC    = `ADCSC_BIT_CYC
) (
  input wire                clk,
  input wire                sys_rst,
  input wire [7:0]          reg_addr,
  input wire [31:0]         reg_wdata,
  input wire                reg_wr,
  input wire                reg_rd,
  input wire [31:0]         reg_rdata,
  input wire [3:0]          pin_level,
  input wire                cmp_in,
  input wire                comparator_en,
  input wire                sample_en,
  input wire [1:0]          mux_sel,
  input wire [RES_BITS-1:0] dac_code,
  input wire                conv_end_irq,
  input wire                irq
);
  reg [7:0] smp_cnt_q;
  reg [2:0] mask_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // length of the current sampling run and a copy of the mask register
  always @(posedge clk) begin
    if (sys_rst) begin
      smp_cnt_q <= 8'h00;
      mask_q    <= 3'h0;
    end else begin
      smp_cnt_q <= sample_en ? smp_cnt_q + 8'h01 : 8'h00;
      if (reg_wr && reg_addr == `ADCSC_OFS_IRQ_MASK) begin
        mask_q <= reg_wdata[2:0];
      end
    end
  end

  // ****
  // properties
  // ****
  sequence s_mode_wr; reg_wr && reg_addr == `ADCSC_OFS_MODE; endsequence
  sequence s_full_sample; $fell(sample_en) && smp_cnt_q == SAMPLE_CYC; endsequence
  sequence s_port_rd; reg_rd && reg_addr == `ADCSC_OFS_PORT; endsequence

  property p_end_pulse; conv_end_irq |=> !conv_end_irq; endproperty
  property p_cmpen; s_mode_wr |=> comparator_en == $past(reg_wdata[`ADCSC_MODE_CMPEN_BIT]); endproperty
  property p_sample_len; sample_en |-> smp_cnt_q < SAMPLE_CYC; endproperty
  property p_dac_start; s_full_sample |-> dac_code == {1'b1, {(RES_BITS-1){1'b0}}}; endproperty
  property p_mux_hold; s_full_sample |-> $stable(mux_sel)[*8]; endproperty
  property p_irq_up; conv_end_irq && mask_q[0] |-> ##[0:2] irq; endproperty
  property p_irq_quiet; (mask_q == 3'h0)[*3] |-> !irq; endproperty
  // pins held for three cycles have crossed the synchroniser
  property p_port_read;
    s_port_rd ##0 (pin_level == $past(pin_level) && pin_level == $past(pin_level, 2) &&
                   pin_level == $past(pin_level, 3))
      |=> reg_rdata == {28'h0, $past(pin_level)};
  endproperty
  property p_rdata_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty

  a_end_pulse: assert property (p_end_pulse) else $error("end request wider than one cycle");
  a_cmpen: assert property (p_cmpen) else $error("comparator enable not from mode bit 0");
  a_sample_len: assert property (p_sample_len) else $error("sampling interval too long");
  a_dac_start: assert property (p_dac_start) else $error("first trial code wrong");
  a_mux_hold: assert property (p_mux_hold) else $error("channel moved during conversion");
  a_irq_up: assert property (p_irq_up) else $error("unmasked end event gave no irq");
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq raised with all masked");
  a_port_read: assert property (p_port_read) else $error("port read differs from pins");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
endmodule

bind adcsc_ctrl adcsc_ctrl_chk #(.RES_BITS(RES_BITS), .SAMPLE_CYC(SAMPLE_CYC), .BIT_CYC(BIT_CYC))
  u_adcsc_ctrl_chk (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_level(pin_level), .cmp_in(cmp_in),
  .comparator_en(comparator_en), .sample_en(sample_en), .mux_sel(mux_sel), .dac_code(dac_code),
  .conv_end_irq(conv_end_irq), .irq(irq));

// ==== testbench/adcsc_analog_model.sv ====
// four analog sources and the comparator in front of the converter.
// assumes a 10-bit trial code and levels packed ten bits per channel.
`timescale 1ns/10ps

module adcsc_analog_model (
  input  wire        clk,
  input  wire [39:0] level,
  input  wire        comparator_en,
  input  wire        sample_en,
  input  wire [1:0]  mux_sel,
  input  wire [9:0]  dac_code,
  output wire        cmp_in
);
  reg [9:0] held_q = 10'h000;
  reg       tog_q  = 1'b0;

  // the capacitor follows the selected input only while sampling
  always @(posedge clk) begin
    tog_q <= ~tog_q;
    if (sample_en) begin
      held_q <= level[mux_sel*6'd10 +: 10];
    end
  end

  // a disabled comparator gives no answer, so it toggles rather than hold a level
  assign cmp_in = comparator_en ? (held_q >= dac_code) : tog_q;
endmodule

// ==== testbench/adc_sequencing_cautions_test.sv ====
// self-checking bench for the converter control block with an analog source model.
// assumes the register map header and a single 250 MHz clock.
`timescale 1ns/10ps
`include "adcsc_map.vh"

module adc_sequencing_cautions_test;
  localparam [7:0] SMP = 8'h10;
  reg         clk;
  reg         sys_rst;
  reg  [7:0]  reg_addr;
  reg  [31:0] reg_wdata;
  reg         reg_wr;
  reg         reg_rd;
  wire [31:0] reg_rdata;
  reg  [3:0]  pin_level;
  wire        cmp_in;
  wire        comparator_en;
  wire        sample_en;
  wire [1:0]  mux_sel;
  wire [9:0]  dac_code;
  wire        conv_end_irq;
  wire        irq;
  reg  [39:0] level;
  reg  [31:0] d;
  reg  [31:0] exp_q[$];
  integer     err_count;
  integer     compares;
  integer     cyc;
  integer     i;
  integer     n;

  adcsc_ctrl #(.RES_BITS(10), .SAMPLE_CYC(SMP), .BIT_CYC(8'h04)) u_adcsc_ctrl (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_level(pin_level), .cmp_in(cmp_in), .comparator_en(comparator_en), .sample_en(sample_en),
    .mux_sel(mux_sel), .dac_code(dac_code), .conv_end_irq(conv_end_irq), .irq(irq));
  adcsc_analog_model u_adcsc_analog_model (.clk(clk), .level(level), .comparator_en(comparator_en),
    .sample_en(sample_en), .mux_sel(mux_sel), .dac_code(dac_code), .cmp_in(cmp_in));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // hang guard, well above the few thousand cycles the tests need
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      $display("unexpected at %0t: timeout", $time);
      final_report;
    end
  end

  task final_report;
    begin
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
        $display("bench passed");
      end else begin
        $display("bench failed");
      end
      $finish;
    end
  endtask

  task chk(input [31:0] got, input [31:0] want, input [8*12-1:0] what);
    begin
      compares = compares + 1;
      if (got !== want) begin
        err_count = err_count + 1;
        $display("unexpected at %0t: %0s got %h want %h", $time, what, got, want);
      end
    end
  endtask

  // one-cycle strobes; the next call leaves one idle cycle between them
  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask

  task rd(input [7:0] a, output [31:0] v);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
    end
  endtask

  function [31:0] word(input [1:0] ch);
    word = {14'h0, ch, 6'h0, level[ch*6'd10 +: 10]};
  endfunction

  // gap < 0 starts with the comparator off; otherwise enable, wait, start
  task start(input [1:0] ch, input integer gap);
    begin
      wr(`ADCSC_OFS_MODE, 32'h0);
      wr(`ADCSC_OFS_STATUS, 32'h1);
      rd(`ADCSC_OFS_IRQ_STAT, d);
      wr(`ADCSC_OFS_CHAN, {30'h0, ch});
      if (gap >= 0) begin
        wr(`ADCSC_OFS_MODE, 32'h1);
        repeat (gap) @(posedge clk);
      end
      wr(`ADCSC_OFS_MODE, gap >= 0 ? 32'h81 : 32'h80);
    end
  endtask

  task wait_end;
    begin
      n = 0;
      @(posedge clk);
      #1;
      while (conv_end_irq !== 1'b1 && n < 300) begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
      chk({31'h0, conv_end_irq}, 32'h1, "end request");
    end
  endtask

  task check_result(input suspect);
    begin
      rd(`ADCSC_OFS_RESULT, d);
      chk(d, exp_q.pop_front(), "result");
      rd(`ADCSC_OFS_STATUS, d);
      chk(d & 32'h3, {30'h0, suspect, 1'b1}, "status");
    end
  endtask

  // ****
  // main sequence
  // ****
  initial begin
    sys_rst   = 1'b1;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    pin_level = 4'h0;
    level     = 40'h0;
    err_count = 0;
    compares  = 0;
    cyc       = 0;
    void'($urandom(12));
    repeat (20) @(posedge clk);
    sys_rst   <= 1'b0;
    pin_level <= $urandom;
    // reset values, an unmapped word, the shared pins
    wr(8'h1C, 32'hFFFFFFFF);
    for (i = 0; i < 8; i = i + 1) begin
      rd(8'(i * 4), d);
      if (i != 2 && i != 6) chk(d, 32'h0, "reset value");
    end
    rd(`ADCSC_OFS_PORT, d);
    chk(d, {28'h0, pin_level}, "port pins");
    chk({31'h0, comparator_en}, 32'h0, "cmp enable");
    $display("test reset done");
    // settled starts on every channel, end event unmasked
    level[39:32] = $urandom;
    level[31:0]  = $urandom;
    wr(`ADCSC_OFS_IRQ_MASK, 32'h1);
    for (i = 0; i < 4; i = i + 1) begin
      pin_level <= $urandom;
      exp_q.push_back(word(i[1:0]));
      start(i[1:0], 260);
      wait_end;
      check_result(1'b0);
      chk({31'h0, irq}, 32'h1, "irq level");
      rd(`ADCSC_OFS_IRQ_STAT, d);
      chk(d & 32'h3, 32'h1, "irq status");
    end
    $display("test channels done");
    // early starts give a suspect first result, masked so irq stays low
    wr(`ADCSC_OFS_IRQ_MASK, 32'h0);
    for (i = 0; i < 2; i = i + 1) begin
      start(2'h3, i == 0 ? -1 : 240);
      wait_end;
      rd(`ADCSC_OFS_STATUS, d);
      chk(d & 32'h3, 32'h3, "suspect");
      rd(`ADCSC_OFS_IRQ_STAT, d);
      chk(d & 32'h2, 32'h2, "suspect irq");
      chk({31'h0, irq}, 32'h0, "masked irq");
    end
    $display("test start-up done");
    // channel change in mid-conversion
    exp_q.push_back(word(2'h1));
    exp_q.push_back(word(2'h1));
    exp_q.push_back(word(2'h2));
    start(2'h1, 260);
    wait_end;
    check_result(1'b0);
    repeat (SMP + 8'h08) @(posedge clk);
    wr(`ADCSC_OFS_CHAN, 32'h2);
    rd(`ADCSC_OFS_STATUS, d);
    chk(d & 32'h1, 32'h1, "done kept");
    rd(`ADCSC_OFS_PORT, d);
    rd(`ADCSC_OFS_IRQ_STAT, d);
    chk(d & 32'h4, 32'h4, "busy port");
    wait_end;
    check_result(1'b0);
    wait_end;
    check_result(1'b0);
    $display("test channel change done");
    // clearing run in the bit phase drops the conversion
    repeat (SMP + 8'h04) @(posedge clk);
    wr(`ADCSC_OFS_MODE, 32'h1);
    n = 0;
    repeat (120) begin
      @(posedge clk);
      #1;
      if (conv_end_irq === 1'b1) n = n + 1;
    end
    chk(n, 0, "abort");
    rd(`ADCSC_OFS_STATUS, d);
    chk(d & 32'h8, 32'h0, "busy");
    rd(`ADCSC_OFS_MODE, d);
    chk(d, 32'h1, "mode");
    $display("test abort done");
    final_report;
  end
endmodule
